// ### iocfs_field.sv
// Purpose: Field-side model of the contacts wired to the five I/O channels.
// Assumes: Dry contacts; a closed contact reads high at the block.
// Notes: A driven channel has no contact behind it, so it reads open.
`timescale 1ns/1ps
module iocfs_field (
  // Block side
  input wire logic [iocfs_pkg::NCH-1:0] ch_oe,
  // Bench requests
  input wire logic [iocfs_pkg::NCH-1:0] close_req,
  // Contact levels seen by the block
  output logic [iocfs_pkg::NCH-1:0] contact_closed
);
  import iocfs_pkg::*;
  initial contact_closed = '0;
  // Levels land 3 ns off the edge, as an unsynchronised switch would
  always @(close_req or ch_oe) contact_closed <= #3 close_req & ~ch_oe;
endmodule : iocfs_field

// ### iocfs_hold.sv
// Purpose: Freezes setpoint and program position while the hold input is open.
// Assumes: tick is a one-cycle advance pulse from the profile engine.
// Notes: Position is never reset by hold, only by sys_rst.
`timescale 1ns/1ps
module iocfs_hold (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Hold control and results
  iocfs_hold_if.unit hif
);
  import iocfs_pkg::*;

  logic [SP_W-1:0] sp_q;
  logic [POS_W-1:0] pos_q;

  // Setpoint keeps its value from the moment of suspension
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sp_q <= '0;
      pos_q <= '0;
    end else if (!hif.hold) begin
      sp_q <= hif.live_sp; // R10
      if (hif.tick)
        pos_q <= pos_q + 16'h0001; // R11
    end
  end

  assign hif.active_sp = sp_q;
  assign hif.pos = pos_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  AST_HOLD_FREEZE: assert property (hif.hold |=> ($stable(sp_q) && $stable(pos_q))) // R10
    else $error("setpoint or position moved during hold");
  AST_RESUME_POS: assert property (!hif.hold && hif.tick |=> // R11
    pos_q == $past(pos_q) + 16'h0001)
    else $error("position did not advance from held point");
  COV_HOLD_RESUME: cover property (hif.hold ##1 !hif.hold ##1 hif.tick);
endmodule : iocfs_hold

// ### iocfs_hold_if.sv
// Purpose: Carries program hold control and setpoint between selector and hold unit.
// Assumes: Both ends run on mclk.
// Notes: No clocking block; plain signals.
`timescale 1ns/1ps
interface iocfs_hold_if;
  import iocfs_pkg::*;
  logic hold;
  logic tick;
  logic [SP_W-1:0] live_sp;
  logic [SP_W-1:0] active_sp;
  logic [POS_W-1:0] pos;
  modport ctl (output hold, output tick, output live_sp, input active_sp, input pos);
  modport unit (input hold, input tick, input live_sp, output active_sp, output pos);
endinterface : iocfs_hold_if

// ### iocfs_pkg.sv
// Purpose: Shared constants and helpers for the I/O channel function selector.
// Assumes: Five channels; the fifth is the one with the current output driver.
// Notes: Channel indices are zero based; channel three is index 2.
package iocfs_pkg;

  // Channel geometry
  localparam int NCH = 5;
  localparam int CODE_W = 5;
  localparam int NFN = 17;
  localparam int SP_W = 16;
  localparam int POS_W = 16;
  localparam int NALM = 4;

  // Channel indices with restricted function sets
  localparam logic [2:0] CH3_IDX = 3'h2;
  localparam logic [2:0] CH4_IDX = 3'h3;
  localparam logic [2:0] CH5_IDX = 3'h4;

  // Function codes, one per selectable channel function
  localparam logic [CODE_W-1:0] FN_OFF = 5'h00;
  localparam logic [CODE_W-1:0] FN_AL1 = 5'h01;
  localparam logic [CODE_W-1:0] FN_AL2 = 5'h02;
  localparam logic [CODE_W-1:0] FN_AL3 = 5'h03;
  localparam logic [CODE_W-1:0] FN_AL4 = 5'h04;
  localparam logic [CODE_W-1:0] FN_CTRL = 5'h05;
  localparam logic [CODE_W-1:0] FN_DI_AM = 5'h06;
  localparam logic [CODE_W-1:0] FN_DI_RUN = 5'h07;
  localparam logic [CODE_W-1:0] FN_DI_RSP = 5'h08;
  localparam logic [CODE_W-1:0] FN_DI_HOLD = 5'h09;
  localparam logic [CODE_W-1:0] FN_DI_PR1 = 5'h0A;
  localparam logic [CODE_W-1:0] FN_AO_C020 = 5'h0B;
  localparam logic [CODE_W-1:0] FN_AO_C420 = 5'h0C;
  localparam logic [CODE_W-1:0] FN_AO_P020 = 5'h0D;
  localparam logic [CODE_W-1:0] FN_AO_P420 = 5'h0E;
  localparam logic [CODE_W-1:0] FN_AO_S020 = 5'h0F;
  localparam logic [CODE_W-1:0] FN_AO_S420 = 5'h10;

  // Reset value of every channel field
  localparam logic [CODE_W-1:0] CFG_RST = FN_OFF;

  // Serial command that drives an unassigned channel
  localparam logic [7:0] SER_CMD_FORCE = 8'h05;

  // Analog source selection
  localparam logic [1:0] AO_SRC_CTRL = 2'h0;
  localparam logic [1:0] AO_SRC_PV = 2'h1;
  localparam logic [1:0] AO_SRC_SP = 2'h2;

  // Channel may hold a digital input (five always; three and four need the digital option; relay option wins on three)
  function automatic logic iocfs_di_ok(input logic [2:0] ch, input logic dio,
                                       input logic r3);
    iocfs_di_ok = (ch == CH5_IDX) || (ch == CH4_IDX && dio) ||
                  (ch == CH3_IDX && dio && !r3);
  endfunction : iocfs_di_ok

  // Whether a function code is legal on a channel under the fitted options
  function automatic logic iocfs_fn_valid(input logic [2:0] ch, input logic [CODE_W-1:0] f,
                                          input logic dio, input logic r3);
    if (ch > CH5_IDX || f > FN_AO_S420)
      iocfs_fn_valid = 1'b0;
    else if (f >= FN_DI_AM && f <= FN_DI_PR1)
      iocfs_fn_valid = iocfs_di_ok(ch, dio, r3);
    else if (f >= FN_AO_C020)
      iocfs_fn_valid = (ch == CH5_IDX);
    else
      iocfs_fn_valid = 1'b1;
  endfunction : iocfs_fn_valid

  // Mask of channels configured with a given function
  function automatic logic [NCH-1:0] iocfs_fn_mask(input logic [NCH-1:0][CODE_W-1:0] cfg,
                                                   input logic [CODE_W-1:0] f);
    for (int i = 0; i < NCH; i++)
      iocfs_fn_mask[i] = (cfg[i] == f);
  endfunction : iocfs_fn_mask

endpackage : iocfs_pkg

// ### iocfs_sync.sv
// Purpose: Two-stage synchroniser for pin levels.
// Assumes: Inputs are slow levels such as contacts and option straps.
// Notes: First stage feeds only the second stage.
`timescale 1ns/1ps
module iocfs_sync #(
  parameter int W = 7
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // Two flops; no contact bounce filtering here
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : iocfs_sync

// ### iocfs_top.sv
// Purpose: Assigns one function to each of five I/O channels and applies input functions.
// Assumes: contact_closed and option straps are asynchronous pins; all else is on mclk.
// Notes: Outputs follow configuration one cycle after the field updates.
// Operation
// R1: Unassigned channel is neither driven nor read by any function.
// R2: Unassigned channel stays reachable by serial command 5.
// R3: Any alarm may go to any channel, which follows the alarm state.
// R4: Any channel takes control output; logic pulse only on digital-driver channels.
// R5: Digital inputs only on channels three, four if fitted, and five.
// R6: Auto/manual input: closed means manual, open means automatic.
// R7: Run input: closed enables control and alarm outputs, open disables.
// R8: Remote setpoint input: closed selects remote, open selects main setpoint.
// R9: Program hold input: closed lets program advance, open suspends it.
// R10: While suspended, control stays active at the setpoint held at suspension.
// R11: On reclosing, program continues from the exact suspended point.
// R12: Offered function list per channel holds only its valid functions.
// R13: Analog functions: control, PV and SP, each in 0-20 or 4-20 mA.
// R14: Basic build: channels one, two relays; five current, digital out, digital in.
// R15: Digital option gives three and four in/out; relay option makes three relay.
// R16: Program-one input: closed starts program one, open returns to main setpoint.
// R17: Analog functions only on channel five, refused elsewhere.
// R18: Each channel has its own field, reset to the no-function code.
`timescale 1ns/1ps
module iocfs_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Option straps (pins)
  input wire logic opt_dio,
  input wire logic opt_relay3,
  // Configuration write and result
  input wire logic cfg_we,
  input wire logic [2:0] cfg_chan,
  input wire logic [iocfs_pkg::CODE_W-1:0] cfg_code,
  output logic cfg_ack,
  output logic cfg_err,
  // Configuration readback and offered list
  input wire logic [2:0] list_chan,
  output logic [iocfs_pkg::NFN-1:0] list_mask,
  output logic [iocfs_pkg::NCH*iocfs_pkg::CODE_W-1:0] cfg_codes,
  // Serial link drive of unassigned channels
  input wire logic ser_we,
  input wire logic [7:0] ser_cmd,
  input wire logic [2:0] ser_chan,
  input wire logic ser_level,
  // Controller sources
  input wire logic [iocfs_pkg::NALM-1:0] alarm_state,
  input wire logic ctrl_demand,
  input wire logic prog_tick,
  input wire logic [iocfs_pkg::SP_W-1:0] live_sp,
  // Channel pins
  input wire logic [iocfs_pkg::NCH-1:0] contact_closed,
  output logic [iocfs_pkg::NCH-1:0] ch_out,
  output logic [iocfs_pkg::NCH-1:0] ch_oe,
  output logic [iocfs_pkg::NCH-1:0] ch_pulse_form,
  // Analog output selection on channel five
  output logic ao_en,
  output logic [1:0] ao_src,
  output logic ao_live_zero,
  // Input-driven modes
  output logic manual_mode,
  output logic run_enable,
  output logic remote_sp_sel,
  output logic program_advance,
  output logic program_one_select,
  output logic [iocfs_pkg::SP_W-1:0] active_sp,
  output logic [iocfs_pkg::POS_W-1:0] prog_pos
);
  import iocfs_pkg::*;

  logic [NCH-1:0][CODE_W-1:0] cfg_q;
  logic [NCH-1:0] ser_own_q;
  logic [NCH-1:0] ser_lvl_q;
  logic [NCH-1:0] ch_out_q, ch_out_d;
  logic [NCH-1:0] ch_oe_q, ch_oe_d;
  logic [NCH-1:0] pulse_q, pulse_d;
  logic cfg_ack_q, cfg_err_q;
  logic [NFN-1:0] list_q, list_d;
  logic manual_q, run_q, remote_q, advance_q, pr1_q;
  logic ao_en_q, ao_live_zero_q;
  logic [1:0] ao_src_q;
  logic [6:0] pin_s;

  // Contacts and straps cross into mclk before use
  iocfs_sync #(.W(7)) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .d({opt_relay3, opt_dio, contact_closed}),
    .q(pin_s)
  );

  wire [NCH-1:0] contact_s = pin_s[NCH-1:0];
  wire dio_s = pin_s[5];
  wire r3_s = pin_s[6];

  // Write decode; an illegal pair leaves the field untouched
  wire cfg_ok = iocfs_fn_valid(cfg_chan, cfg_code, dio_s, r3_s); // R5 R14 R15 R17
  wire cfg_take = cfg_we && cfg_ok;
  wire ser_go = ser_we && (ser_cmd == SER_CMD_FORCE) && (ser_chan <= CH5_IDX);

  // Per-function channel masks; an unassigned channel matches only off_m
  wire [NCH-1:0] am_m = iocfs_fn_mask(cfg_q, FN_DI_AM); // R1
  wire [NCH-1:0] run_m = iocfs_fn_mask(cfg_q, FN_DI_RUN);
  wire [NCH-1:0] rsp_m = iocfs_fn_mask(cfg_q, FN_DI_RSP);
  wire [NCH-1:0] hold_m = iocfs_fn_mask(cfg_q, FN_DI_HOLD);
  wire [NCH-1:0] pr1_m = iocfs_fn_mask(cfg_q, FN_DI_PR1);
  wire [NCH-1:0] off_m = iocfs_fn_mask(cfg_q, FN_OFF);

  // Several channels with one function act as a wired OR of closed contacts
  wire manual_d = |(am_m & contact_s); // R6
  wire run_d = (run_m == '0) || |(run_m & contact_s); // R7
  wire remote_d = |(rsp_m & contact_s); // R8
  wire advance_d = (hold_m == '0) || |(hold_m & contact_s); // R9
  wire pr1_d = |(pr1_m & contact_s); // R16
  wire [CODE_W-1:0] ch5_code = cfg_q[CH5_IDX];

  // Channel fields, writes take one edge
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cfg_q <= {NCH{CFG_RST}}; // R18
    end else if (cfg_take) begin
      cfg_q[cfg_chan] <= cfg_code; // R18
    end
  end

  // Write result pulses
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cfg_ack_q <= 1'b0;
      cfg_err_q <= 1'b0;
    end else begin
      cfg_ack_q <= cfg_take;
      cfg_err_q <= cfg_we && !cfg_ok; // R5 R17
    end
  end

  // Serial ownership of unassigned channels; an assigned channel ignores it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ser_own_q <= '0;
      ser_lvl_q <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (ser_go && ser_chan == 3'(i) && off_m[i]) begin
          ser_own_q[i] <= 1'b1; // R2
          ser_lvl_q[i] <= ser_level; // R2
        end else if (cfg_take && cfg_chan == 3'(i)) begin
          ser_own_q[i] <= 1'b0;
        end
      end
    end
  end

  // Per-channel drive from its function
  always_comb begin
    ch_out_d = '0;
    ch_oe_d = '0;
    pulse_d = '0;
    for (int i = 0; i < NCH; i++) begin
      case (cfg_q[i])
        FN_OFF: begin
          ch_oe_d[i] = ser_own_q[i]; // R1 R2
          ch_out_d[i] = ser_lvl_q[i] & ser_own_q[i];
        end
        FN_AL1, FN_AL2, FN_AL3, FN_AL4: begin
          ch_oe_d[i] = 1'b1;
          ch_out_d[i] = alarm_state[2'(cfg_q[i] - FN_AL1)] & run_q; // R3 R7
        end
        FN_CTRL: begin
          ch_oe_d[i] = 1'b1;
          ch_out_d[i] = ctrl_demand & run_q; // R4 R7 R10
          pulse_d[i] = iocfs_di_ok(3'(i), dio_s, r3_s); // R4
        end
        default: begin
          ch_oe_d[i] = 1'b0;
          ch_out_d[i] = 1'b0;
        end
      endcase
    end
  end

  // Offered function list for the queried channel
  always_comb begin
    list_d = '0;
    for (int f = 0; f < NFN; f++)
      list_d[f] = iocfs_fn_valid(list_chan, CODE_W'(f), dio_s, r3_s); // R12
  end

  // Registered pins, modes and list
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ch_out_q <= '0;
      ch_oe_q <= '0;
      pulse_q <= '0;
      list_q <= '0;
      manual_q <= 1'b0;
      run_q <= 1'b1;
      remote_q <= 1'b0;
      advance_q <= 1'b1;
      pr1_q <= 1'b0;
    end else begin
      ch_out_q <= ch_out_d;
      ch_oe_q <= ch_oe_d;
      pulse_q <= pulse_d;
      list_q <= list_d;
      manual_q <= manual_d;
      run_q <= run_d;
      remote_q <= remote_d;
      advance_q <= advance_d;
      pr1_q <= pr1_d;
    end
  end

  // Analog function on channel five: source and live zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ao_en_q <= 1'b0;
      ao_src_q <= AO_SRC_CTRL;
      ao_live_zero_q <= 1'b0;
    end else begin
      ao_en_q <= (ch5_code >= FN_AO_C020); // R13 R14
      ao_live_zero_q <= (ch5_code == FN_AO_C420) || (ch5_code == FN_AO_P420) ||
                        (ch5_code == FN_AO_S420); // R13
      if (ch5_code == FN_AO_P020 || ch5_code == FN_AO_P420)
        ao_src_q <= AO_SRC_PV;
      else if (ch5_code == FN_AO_S020 || ch5_code == FN_AO_S420)
        ao_src_q <= AO_SRC_SP;
      else
        ao_src_q <= AO_SRC_CTRL;
    end
  end

  // Program hold unit keeps setpoint and position across suspension
  iocfs_hold_if hif ();
  assign hif.hold = !advance_q; // R9
  assign hif.tick = prog_tick;
  assign hif.live_sp = live_sp;

  iocfs_hold u_hold (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .hif(hif)
  );

  // Output ports
  assign cfg_ack = cfg_ack_q;
  assign cfg_err = cfg_err_q;
  assign list_mask = list_q;
  assign cfg_codes = cfg_q;
  assign ch_out = ch_out_q;
  assign ch_oe = ch_oe_q;
  assign ch_pulse_form = pulse_q;
  assign ao_en = ao_en_q;
  assign ao_src = ao_src_q;
  assign ao_live_zero = ao_live_zero_q;
  assign manual_mode = manual_q;
  assign run_enable = run_q;
  assign remote_sp_sel = remote_q;
  assign program_advance = advance_q;
  assign program_one_select = pr1_q;
  assign active_sp = hif.active_sp;
  assign prog_pos = hif.pos;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  AST_OFF_UNDRIVEN: assert property ((off_m[0] && !ser_own_q[0]) |=> !ch_oe_q[0]) // R1
    else $error("unassigned channel driven without serial ownership");
  AST_SER_DRIVE: assert property ((ser_go && ser_chan == 3'h0 && off_m[0] && !cfg_we) // R2
                                  |=> ##1 ch_oe_q[0])
    else $error("serial command did not drive unassigned channel");
  AST_ALARM_FOLLOW: assert property ((cfg_q[1] == FN_AL1 && run_q) // R3
                                     |=> ch_out_q[1] == $past(alarm_state[0]))
    else $error("alarm channel not following alarm state");
  AST_DI_REJECT: assert property ((cfg_we && cfg_chan == 3'h0 && cfg_code == FN_DI_RUN) // R5
                                  |=> cfg_err_q && !cfg_ack_q)
    else $error("digital input accepted on channel one");
  AST_MANUAL: assert property ((cfg_q[4] == FN_DI_AM && contact_s[4]) |=> manual_q) // R6
    else $error("closed contact did not select manual");
  AST_RUN_GATE: assert property ((cfg_q[0] >= FN_AL1 && cfg_q[0] <= FN_CTRL && !run_q) // R7
                                 |=> !ch_out_q[0])
    else $error("control or alarm output active while stopped");
  AST_REMOTE: assert property ((rsp_m == '0) |=> !remote_q) // R8
    else $error("remote setpoint without its input");
  AST_AO_REJECT: assert property ( // R17
    (cfg_we && cfg_chan != CH5_IDX && cfg_code >= FN_AO_C020) |=> cfg_err_q)
    else $error("analog function accepted off channel five");
  AST_LIST_AO: assert property ((list_chan == 3'h0) |=> !list_q[FN_AO_C420]) // R12
    else $error("analog function offered on channel one");
  AST_RST_OFF: assert property ($past(sys_rst) |-> // R18
    (cfg_q[2] == FN_OFF && cfg_q[4] == FN_OFF))
    else $error("field not cleared by reset");
  AST_PR1_IDLE: assert property ((pr1_m == '0) |=> !pr1_q) // R16
    else $error("program one selected without its input");
  AST_UNUSED_AM: assert property ((am_m == '0) |=> !manual_q) // R1 R6
    else $error("manual mode without its input");
  AST_AO_OFF: assert property ((ch5_code < FN_AO_C020) |=> !ao_en_q) // R13 R17
    else $error("analog output enabled without analog function");
  AST_CH5_PULSE: assert property ((cfg_q[4] == FN_CTRL) |=> pulse_q[4]) // R4 R14
    else $error("channel five control lacks logic pulse form");
  AST_CH3_RELAY: assert property (((!dio_s || r3_s) && cfg_q[2] == FN_CTRL) |=> !pulse_q[2]) // R15
    else $error("channel three pulse form without digital driver");

  COV_CFG_AO: cover property (cfg_take && cfg_code == FN_AO_S420);
  COV_SER: cover property (ser_go ##2 ch_oe_q[ser_chan]);
  COV_HOLD: cover property (!advance_q ##1 advance_q);
  COV_PR1: cover property (pr1_q ##1 !pr1_q);
endmodule : iocfs_top

// ### tb_io_channel_function_select.sv
// Purpose: Self-checking bench for the I/O channel function selector.
// Assumes: Straps and contacts are slow levels; the field model sits on the channel pins.
// Notes: Seeded random writes and straps, with directed corners for each function.
`timescale 1ns/1ps
module tb_io_channel_function_select;
  import iocfs_pkg::*;
  // Design inputs
  logic mclk = 1'b0, sys_rst = 1'b1, opt_dio = 1'b0, opt_relay3 = 1'b0;
  logic cfg_we = 1'b0, ser_we = 1'b0, ser_level = 1'b0, ctrl_demand = 1'b0, prog_tick = 1'b0;
  logic [2:0] cfg_chan = 3'h0, list_chan = 3'h0, ser_chan = 3'h0;
  logic [CODE_W-1:0] cfg_code = 5'h00;
  logic [7:0] ser_cmd = 8'h00;
  logic [NALM-1:0] alarm_state = 4'h0;
  logic [SP_W-1:0] live_sp = 16'h0000;
  logic [NCH-1:0] close_req = 5'h00;
  logic [NCH-1:0] contact_closed;
  // Design outputs
  logic cfg_ack, cfg_err, ao_en, ao_live_zero, manual_mode, run_enable, remote_sp_sel;
  logic program_advance, program_one_select;
  logic [NFN-1:0] list_mask;
  logic [NCH*CODE_W-1:0] cfg_codes;
  logic [NCH-1:0] ch_out, ch_oe, ch_pulse_form;
  logic [1:0] ao_src;
  logic [SP_W-1:0] active_sp;
  logic [POS_W-1:0] prog_pos;
  // Bench state
  int failures = 0;
  int cmp_count = 0;
  int sel, k;
  logic [CODE_W-1:0] shadow [NCH];
  logic [POS_W-1:0] p0;
  logic [SP_W-1:0] s0;

  always #4 mclk = ~mclk;

  iocfs_top u_iocfs_top (
    .mclk(mclk), .sys_rst(sys_rst), .opt_dio(opt_dio), .opt_relay3(opt_relay3),
    .cfg_we(cfg_we), .cfg_chan(cfg_chan), .cfg_code(cfg_code), .cfg_ack(cfg_ack),
    .cfg_err(cfg_err), .list_chan(list_chan), .list_mask(list_mask), .cfg_codes(cfg_codes),
    .ser_we(ser_we), .ser_cmd(ser_cmd), .ser_chan(ser_chan), .ser_level(ser_level),
    .alarm_state(alarm_state), .ctrl_demand(ctrl_demand), .prog_tick(prog_tick),
    .live_sp(live_sp), .contact_closed(contact_closed), .ch_out(ch_out), .ch_oe(ch_oe),
    .ch_pulse_form(ch_pulse_form), .ao_en(ao_en), .ao_src(ao_src),
    .ao_live_zero(ao_live_zero), .manual_mode(manual_mode), .run_enable(run_enable),
    .remote_sp_sel(remote_sp_sel), .program_advance(program_advance),
    .program_one_select(program_one_select), .active_sp(active_sp), .prog_pos(prog_pos)
  );

  iocfs_field u_iocfs_field (.ch_oe(ch_oe), .close_req(close_req),
    .contact_closed(contact_closed));

  // Expected legality, kept apart from the design's own helpers
  function automatic logic fn_ok(input int ch, input int f, input logic dio, input logic r3);
    if (ch > 4 || f > 16) return 1'b0;
    if (f >= 11) return ch == 4;
    if (f >= 6) return ch == 4 || (ch == 3 && dio) || (ch == 2 && dio && !r3);
    return 1'b1;
  endfunction : fn_ok

  // Mode output driven by a digital input code; all are high on a closed contact
  function automatic logic mode_of(input int f);
    case (f)
      6: return manual_mode;
      7: return run_enable;
      8: return remote_sp_sel;
      9: return program_advance;
      default: return program_one_select;
    endcase
  endfunction : mode_of

  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      failures++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask : wt

  task automatic summarize();
    $display("checks %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  task automatic do_reset();
    @(posedge mclk);
    sys_rst <= 1'b1;
    close_req <= '0;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    foreach (shadow[c]) shadow[c] = FN_OFF;
    @(negedge mclk);
    chk(cfg_codes === '0 && ch_oe === '0 && run_enable === 1'b1, "reset state");
    chk(program_advance === 1'b1 && manual_mode === 1'b0, "reset modes");
  endtask : do_reset

  // One write, its answer, and every field afterwards
  task automatic cfg_wr(input int ch, input int f);
    logic ok;
    ok = fn_ok(ch, f, opt_dio, opt_relay3);
    @(posedge mclk);
    cfg_we <= 1'b1;
    cfg_chan <= 3'(ch);
    cfg_code <= 5'(f);
    @(posedge mclk);
    cfg_we <= 1'b0;
    @(negedge mclk);
    for (int i = 0; i < 3; i++) if (cfg_ack !== 1'b1 && cfg_err !== 1'b1) @(negedge mclk);
    chk(cfg_ack === ok && cfg_err === !ok, "config answer");
    if (ok) shadow[ch] = 5'(f);
    for (int c = 0; c < NCH; c++) chk(cfg_codes[c*CODE_W +: CODE_W] === shadow[c], "field");
  endtask : cfg_wr

  task automatic ser_req(input int cmd, input int ch, input logic lv);
    @(posedge mclk);
    ser_we <= 1'b1;
    ser_cmd <= 8'(cmd);
    ser_chan <= 3'(ch);
    ser_level <= lv;
    @(posedge mclk);
    ser_we <= 1'b0;
    wt(3);
  endtask : ser_req

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      prog_tick <= 1'b1;
      @(posedge mclk);
      prog_tick <= 1'b0;
    end
    wt(2);
  endtask : tick

  task automatic contact(input int ch, input logic v);
    @(posedge mclk);
    close_req[ch] <= v;
    wt(5);
  endtask : contact

  // Hang guard, well beyond the few hundred cycles the tests take
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    $display("mismatch at %0t: watchdog", $time);
    summarize();
  end

  initial begin
    void'($urandom(32'hA085));
    do_reset();
    // Strap corners first, then random straps; lists and writes under each
    for (int r = 0; r < 4; r++) begin
      @(posedge mclk);
      opt_dio <= (r < 2) ? 1'b1 : 1'($urandom);
      opt_relay3 <= (r == 1) ? 1'b1 : (r == 0) ? 1'b0 : 1'($urandom);
      wt(4);
      for (int l = 0; l < 6; l++) begin
        @(posedge mclk);
        list_chan <= 3'(l);
        wt(2);
        for (int f = 0; f < NFN; f++)
          chk(list_mask[f] === fn_ok(l, f, opt_dio, opt_relay3), "list");
      end
      cfg_wr(2, 6);
      cfg_wr(3, 10);
      cfg_wr(0, 11);
      cfg_wr(0, 7);
      cfg_wr(4, 17);
      repeat (12) cfg_wr($urandom_range(6), $urandom_range(20));
    end
    $display("test config done");
    do_reset();
    // Random alarm onto random channel, then back to unused
    for (int i = 0; i < 8; i++) begin
      sel = $urandom_range(4);
      k = $urandom_range(3);
      @(posedge mclk);
      alarm_state <= 4'($urandom);
      cfg_wr(sel, k + 1);
      wt(2);
      chk(ch_oe[sel] === 1'b1 && ch_out[sel] === alarm_state[k], "alarm route");
      cfg_wr(sel, 0);
      wt(2);
      chk(ch_oe[sel] === 1'b0, "unused driven");
    end
    $display("test alarm done");
    ser_req(5, 1, 1'b1);
    chk(ch_oe[1] === 1'b1 && ch_out[1] === 1'b1, "serial drive");
    ser_req(4, 0, 1'b1);
    chk(ch_oe[0] === 1'b0, "other command");
    ser_req(5, 0, 1'b0);
    chk(ch_oe[0] === 1'b1 && ch_out[0] === 1'b0, "serial low");
    cfg_wr(1, 1);
    ser_req(5, 1, !alarm_state[0]);
    chk(ch_out[1] === alarm_state[0], "serial on assigned");
    $display("test serial done");
    // Each input function on channel five, alarm on channel one shows run gating
    @(posedge mclk);
    alarm_state <= 4'hF;
    cfg_wr(0, 1);
    for (int f = 6; f <= 10; f++) begin
      cfg_wr(4, f);
      for (int v = 1; v >= 0; v--) begin
        contact(4, 1'(v));
        chk(mode_of(f) === 1'(v), "input mode");
        chk(ch_out[0] === (f != 7 || v != 0), "run gate");
      end
    end
    cfg_wr(4, 0);
    contact(4, 1'b1);
    chk(manual_mode === 1'b0 && run_enable === 1'b1 && remote_sp_sel === 1'b0, "unused in");
    chk(program_advance === 1'b1 && program_one_select === 1'b0, "unused in");
    contact(4, 1'b0);
    $display("test inputs done");
    @(posedge mclk);
    opt_relay3 <= 1'b1;
    opt_dio <= 1'b1;
    cfg_wr(4, 5);
    cfg_wr(0, 5);
    cfg_wr(2, 5);
    cfg_wr(3, 5);
    wt(2);
    chk(ch_pulse_form[4] === 1'b1 && ch_pulse_form[0] === 1'b0, "pulse form");
    chk(ch_pulse_form[2] === 1'b0 && ch_pulse_form[3] === 1'b1, "option pulse");
    for (int f = 11; f <= 16; f++) begin
      cfg_wr(4, f);
      wt(2);
      chk(ao_en === 1'b1 && ao_src === 2'((f - 11) / 2), "analog source");
      chk(ao_live_zero === 1'((f - 11) % 2), "analog range");
    end
    $display("test outputs done");
    // Hold: freeze, control stays on, resume from the held point
    cfg_wr(4, 9);
    @(posedge mclk);
    ctrl_demand <= 1'b1;
    live_sp <= 16'($urandom);
    contact(4, 1'b1);
    p0 = prog_pos;
    tick(3);
    chk(prog_pos === p0 + 16'h0003 && active_sp === live_sp, "advance");
    contact(4, 1'b0);
    p0 = prog_pos;
    s0 = live_sp;
    @(posedge mclk);
    live_sp <= s0 ^ 16'($urandom_range(1, 65535));
    tick(2);
    chk(prog_pos === p0 && active_sp === s0 && ch_out[0] === 1'b1, "hold");
    contact(4, 1'b1);
    tick(1);
    chk(prog_pos === p0 + 16'h0001 && active_sp === live_sp, "resume");
    $display("test hold done");
    summarize();
  end
endmodule : tb_io_channel_function_select
